// ### pkg/pea_pkg.sv
// shared constants and carriers for the power energy accumulator
package pea_pkg;
    // register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_FMT = 12'h004;
    localparam logic [11:0] ADDR_SNAP = 12'h008;
    localparam logic [11:0] ADDR_STAT = 12'h00c;
    localparam logic [11:0] CH_BASE = 12'h100;
    // word index inside a channel block of 0x20 bytes
    localparam logic [2:0] CH_BUS = 3'h0;
    localparam logic [2:0] CH_SHUNT = 3'h1;
    localparam logic [2:0] CH_BUSAVG = 3'h2;
    localparam logic [2:0] CH_SHAVG = 3'h3;
    localparam logic [2:0] CH_POW = 3'h4;
    localparam logic [2:0] CH_ACCLO = 3'h5;
    localparam logic [2:0] CH_ACCHI = 3'h6;
    localparam logic [2:0] CH_CNT = 3'h7;
    // control fields and value after reset
    localparam int CTRL_ADAPT = 0;
    localparam int CTRL_RATE = 1;
    localparam int CTRL_SLOWCTL = 3;
    localparam int CTRL_SLOWSNAP = 4;
    localparam logic [4:0] CTRL_RST = 5'h09;
    // format fields, one bit per channel
    localparam int FMT_BUSBIP = 0;
    localparam int FMT_SHBIP = 4;
    localparam int FMT_BUSHALF = 8;
    localparam int FMT_SHHALF = 12;
    localparam logic [15:0] FMT_RST = 16'h0000;
    // snapshot command bits
    localparam int SNAP_RESET = 0;
    localparam int SNAP_KEEP = 1;
    // programmed rate codes and their sample shifts
    localparam logic [1:0] RATE_1024 = 2'h0;
    localparam logic [1:0] RATE_256 = 2'h1;
    localparam logic [1:0] RATE_64 = 2'h2;
    localparam logic [1:0] RATE_8 = 2'h3;
    localparam logic [2:0] SH_1024 = 3'h0;
    localparam logic [2:0] SH_256 = 3'h2;
    localparam logic [2:0] SH_64 = 3'h4;
    localparam logic [2:0] SH_8 = 3'h7;
    // averaging window
    localparam logic [3:0] AVG_FULL = 4'h8;
    // saturation limits
    localparam logic [55:0] ACC_MAX = 56'h7fffffffffffff;
    localparam logic [55:0] ACC_MIN = 56'h80000000000000;
    localparam logic [29:0] POW_MAX = 30'h1fffffff;
    localparam logic [29:0] POW_MIN = 30'h20000000;
    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pea_apb_req_t;
    // apb answer
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pea_apb_rsp_t;
    // one finished channel conversion
    typedef struct packed {
        logic valid;
        logic [1:0] ch;
        logic [16:0] bus;
        logic [16:0] shunt;
    } pea_conv_t;
endpackage

// ### verilog/pea_accumulator.sv
// power energy accumulator: formatting, averaging, energy sums, apb registers
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - half span option halves bus span, shunt span or both.
// - half span chosen per channel, separately for bus and shunt.
// - half span in bipolar keeps the low 16 bits of the 17-bit code, saturating on overflow.
// - each channel keeps an eight-sample rolling mean of bus and shunt.
// - rolling means recompute once at each conversion cycle end.
// - readable averages change only on a snapshot, from the host or a slow pin edge.
// - averages become valid only after eight conversion cycles.
// - offset permutation steps through four positions every four cycles.
// - bus and shunt codes are carried as 17-bit two's complement.
// - readable bus and shunt results drop the lowest internal bit unless half span is chosen.
// - configuration picks unipolar or bipolar readable format per quantity.
// - each channel has a 56-bit accumulator and 32-bit counter.
// - power is 17-bit current times the 14 upper bus bits, 30 bits.
// - every power product is added into its channel accumulator.
// - power is signed when bus or shunt is bipolar.
// - adaptive slow samples shift left seven bits before adding.
// - adaptive slow samples advance the counter by 128.
// - adaptive rates below 1024 scale data and count to mimic 1024.
// - adaptive mode on by default, slow-edge snapshot off by default.
// - accumulator saturates at its limit and never wraps.
// - sample counter wraps on overflow and keeps counting.
// - slow pin high selects 8 per second from the next cycle.
module pea_accumulator #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire pea_pkg::pea_apb_req_t apbReq,
    output var pea_pkg::pea_apb_rsp_t apbRsp,
    // conversion results from the sequencer
    input wire pea_pkg::pea_conv_t conv,
    input wire logic cycleDone,
    // reduced-rate pin, asynchronous
    input wire logic slowPin,
    // status towards the analog side
    output var logic [1:0] permSel,
    output var logic slowMode,
    output var logic avgValid
);

    if (NCH < 1 || NCH > 4) begin : g_chk
        $error("NCH must lie between 1 and 4");
    end

    typedef struct packed {
        logic [4:0] ctrl;
        logic [15:0] fmt;
        logic [1:0] slowSync;
        logic slowPrev;
        logic slowActive;
        logic [1:0] perm;
        logic [3:0] fill;
        logic avgValid;
        logic cntOvf;
        logic [NCH-1:0][16:0] lastBus;
        logic [NCH-1:0][16:0] lastShunt;
        logic [NCH-1:0][7:0][16:0] winBus;
        logic [NCH-1:0][7:0][16:0] winShunt;
        logic [NCH-1:0][19:0] sumBus;
        logic [NCH-1:0][19:0] sumShunt;
        logic [NCH-1:0][29:0] pow;
        logic [NCH-1:0][55:0] acc;
        logic [NCH-1:0][31:0] cnt;
        logic [NCH-1:0][15:0] rdBus;
        logic [NCH-1:0][15:0] rdShunt;
        logic [NCH-1:0][15:0] rdBusAvg;
        logic [NCH-1:0][15:0] rdShAvg;
        logic [NCH-1:0][29:0] rdPow;
        logic [NCH-1:0][55:0] rdAcc;
        logic [NCH-1:0][31:0] rdCnt;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pea_state_t;

    pea_state_t q;
    pea_state_t d;

    // format a 17-bit code into its 16-bit readable form
    function automatic logic [15:0] fmt16(input logic [16:0] c, input logic bip, input logic half);
        logic [15:0] r;
        r = c[16:1];
        if (half) begin
            if (bip && c[16] != c[15]) begin
                r = c[16] ? 16'h8000 : 16'h7fff;
            end else if (!bip && c[16]) begin
                r = 16'hffff;
            end else begin
                r = c[15:0];
            end
        end
        return r;
    endfunction

    // sign extension of a code into the window sum width
    function automatic logic [19:0] sx20(input logic [16:0] c);
        return {{3{c[16]}}, c};
    endfunction

    // mean of the window: arithmetic shift right by three
    function automatic logic [16:0] mean17(input logic [19:0] s);
        return s[19:3];
    endfunction

    // sample shift for a programmed rate
    function automatic logic [2:0] rateShift(input logic [1:0] r);
        logic [2:0] s;
        case (r)
            pea_pkg::RATE_256: s = pea_pkg::SH_256;
            pea_pkg::RATE_64: s = pea_pkg::SH_64;
            pea_pkg::RATE_8: s = pea_pkg::SH_8;
            default: s = pea_pkg::SH_1024;
        endcase
        return s;
    endfunction

    // saturating add of a shifted power sample
    function automatic logic [55:0] accAdd(input logic [55:0] a, input logic [29:0] p, input logic [2:0] sh);
        logic [56:0] s;
        s = {a[55], a} + ({{27{p[29]}}, p} << sh);
        if (s[56] != s[55]) begin
            return s[56] ? pea_pkg::ACC_MIN : pea_pkg::ACC_MAX;
        end
        return s[55:0];
    endfunction

    // bus handshake terms
    logic apbSetup;
    logic apbWr;
    assign apbSetup = apbReq.psel && !apbReq.penable;
    assign apbWr = apbReq.psel && apbReq.penable && q.pready && apbReq.pwrite && !q.pslverr;

    // snapshot sources: host command or slow pin edge
    logic slowEdge;
    logic hostSnap;
    logic autoSnap;
    logic snapNow;
    logic snapRst;
    assign slowEdge = q.slowSync[1] != q.slowPrev;
    assign hostSnap = apbWr && apbReq.paddr == pea_pkg::ADDR_SNAP
        && (apbReq.pwdata[pea_pkg::SNAP_RESET] || apbReq.pwdata[pea_pkg::SNAP_KEEP]);
    assign autoSnap = slowEdge && q.ctrl[pea_pkg::CTRL_SLOWSNAP] && q.ctrl[pea_pkg::CTRL_SLOWCTL];
    assign snapNow = hostSnap || autoSnap;
    assign snapRst = (hostSnap && apbReq.pwdata[pea_pkg::SNAP_RESET]) || autoSnap;

    logic [2:0] shAmt;
    assign shAmt = !q.ctrl[pea_pkg::CTRL_ADAPT] ? pea_pkg::SH_1024
        : q.slowActive ? pea_pkg::SH_8 : rateShift(q.ctrl[pea_pkg::CTRL_RATE +: 2]);

    // product of current and upper bus bits
    logic signed [30:0] prodW;
    logic [29:0] prod30;
    logic chBip;
    logic [29:0] addP;
    logic convOk;
    assign convOk = conv.valid && int'(conv.ch) < NCH;
    assign prodW = $signed(conv.shunt) * $signed(conv.bus[16:3]);
    // only minus full scale squared can leave 30 bits
    assign prod30 = (prodW[30] != prodW[29]) ? (prodW[30] ? pea_pkg::POW_MIN : pea_pkg::POW_MAX) : prodW[29:0];
    // signed power when either side bipolar
    assign chBip = q.fmt[pea_pkg::FMT_BUSBIP + int'(conv.ch)] || q.fmt[pea_pkg::FMT_SHBIP + int'(conv.ch)];
    assign addP = (!chBip && prod30[29]) ? 30'h0 : prod30;

    // next-state logic
    always_comb begin
        logic [32:0] cntSum;
        logic [1:0] rch;
        logic [31:0] rd;
        logic err;
        cntSum = 33'h0;
        rch = apbReq.paddr[6:5];
        rd = 32'h0;
        err = 1'b0;
        d = q;

        // slow pin synchroniser, first stage feeds only the second
        d.slowSync = {q.slowSync[0], slowPin};
        d.slowPrev = q.slowSync[1];

        if (snapNow) begin
            for (int i = 0; i < NCH; i++) begin
                d.rdBus[i] = fmt16(q.lastBus[i], q.fmt[pea_pkg::FMT_BUSBIP + i], q.fmt[pea_pkg::FMT_BUSHALF + i]);
                d.rdShunt[i] = fmt16(q.lastShunt[i], q.fmt[pea_pkg::FMT_SHBIP + i], q.fmt[pea_pkg::FMT_SHHALF + i]);
                d.rdBusAvg[i] = fmt16(mean17(q.sumBus[i]), q.fmt[pea_pkg::FMT_BUSBIP + i],
                    q.fmt[pea_pkg::FMT_BUSHALF + i]);
                d.rdShAvg[i] = fmt16(mean17(q.sumShunt[i]), q.fmt[pea_pkg::FMT_SHBIP + i],
                    q.fmt[pea_pkg::FMT_SHHALF + i]);
                d.rdPow[i] = q.pow[i];
                d.rdAcc[i] = q.acc[i];
                d.rdCnt[i] = q.cnt[i];
                if (snapRst) begin
                    d.acc[i] = 56'h0;
                    d.cnt[i] = 32'h0;
                end
            end
        end

        // conversion lands after the snapshot so a coincident sample is kept
        if (convOk) begin
            d.lastBus[conv.ch] = conv.bus;
            d.lastShunt[conv.ch] = conv.shunt;
            d.pow[conv.ch] = addP;
            d.acc[conv.ch] = accAdd(d.acc[conv.ch], addP, shAmt);
            // step is two to the shift
            cntSum = {1'b0, d.cnt[conv.ch]} + (33'h1 << shAmt);
            d.cnt[conv.ch] = cntSum[31:0];
            if (cntSum[32]) begin
                d.cntOvf = 1'b1;
            end
        end

        if (cycleDone) begin
            for (int i = 0; i < NCH; i++) begin
                d.winBus[i] = {q.winBus[i][6:0], q.lastBus[i]};
                d.winShunt[i] = {q.winShunt[i][6:0], q.lastShunt[i]};
                d.sumBus[i] = q.sumBus[i] + sx20(q.lastBus[i]) - sx20(q.winBus[i][7]);
                d.sumShunt[i] = q.sumShunt[i] + sx20(q.lastShunt[i]) - sx20(q.winShunt[i][7]);
            end
            d.perm = q.perm + 2'h1;
            if (q.fill != pea_pkg::AVG_FULL) begin
                d.fill = q.fill + 4'h1;
            end
            d.avgValid = d.fill == pea_pkg::AVG_FULL;
            d.slowActive = q.ctrl[pea_pkg::CTRL_SLOWCTL] && q.slowSync[1];
        end

        // register read decode, done in the setup cycle
        case (apbReq.paddr)
            pea_pkg::ADDR_CTRL: rd = {27'h0, q.ctrl};
            pea_pkg::ADDR_FMT: rd = {16'h0, q.fmt};
            pea_pkg::ADDR_SNAP: rd = 32'h0;
            pea_pkg::ADDR_STAT: rd = {27'h0, q.cntOvf, q.perm, q.slowActive, q.avgValid};
            default: begin
                if (apbReq.paddr[11:7] == pea_pkg::CH_BASE[11:7] && apbReq.paddr[1:0] == 2'h0
                    && int'(rch) < NCH) begin
                    case (apbReq.paddr[4:2])
                        pea_pkg::CH_BUS: rd = {16'h0, q.rdBus[rch]};
                        pea_pkg::CH_SHUNT: rd = {16'h0, q.rdShunt[rch]};
                        pea_pkg::CH_BUSAVG: rd = {16'h0, q.rdBusAvg[rch]};
                        pea_pkg::CH_SHAVG: rd = {16'h0, q.rdShAvg[rch]};
                        pea_pkg::CH_POW: rd = {{2{q.rdPow[rch][29]}}, q.rdPow[rch]};
                        pea_pkg::CH_ACCLO: rd = q.rdAcc[rch][31:0];
                        pea_pkg::CH_ACCHI: rd = {{8{q.rdAcc[rch][55]}}, q.rdAcc[rch][55:32]};
                        default: rd = q.rdCnt[rch];
                    endcase
                end else begin
                    err = 1'b1;
                end
            end
        endcase

        // answer one cycle after setup, error on unmapped address
        d.pready = apbSetup;
        if (apbSetup) begin
            d.prdata = apbReq.pwrite ? 32'h0 : rd;
            d.pslverr = err;
        end else begin
            d.pslverr = 1'b0;
        end

        // writes take effect at the access edge only
        if (apbWr) begin
            case (apbReq.paddr)
                pea_pkg::ADDR_CTRL: d.ctrl = apbReq.pwdata[4:0];
                pea_pkg::ADDR_FMT: d.fmt = apbReq.pwdata[15:0];
                default: d.ctrl = q.ctrl;
            endcase
        end
    end

    // single state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.ctrl <= pea_pkg::CTRL_RST;
            q.fmt <= pea_pkg::FMT_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign apbRsp.prdata = q.prdata;
    assign apbRsp.pready = q.pready;
    assign apbRsp.pslverr = q.pslverr;
    assign permSel = q.perm;
    assign slowMode = q.slowActive;
    assign avgValid = q.avgValid;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // readable averages hold between snapshots
    property p_snapHold;
        !snapNow |=> $stable(q.rdBusAvg);
    endproperty
    a_snapHold: assert property (p_snapHold) else $error("averaged result moved without a snapshot");

    // valid flag exactly when the window is full
    property p_avgValid;
        q.avgValid == (q.fill == pea_pkg::AVG_FULL);
    endproperty
    a_avgValid: assert property (p_avgValid) else $error("average valid before eight cycles");

    // permutation steps once per cycle end
    property p_permStep;
        cycleDone |=> q.perm == $past(q.perm) + 2'h1;
    endproperty
    a_permStep: assert property (p_permStep) else $error("permutation did not step");

    // slow adaptive sample adds 128 counts
    property p_cntSlow;
        convOk && conv.ch == 2'h0 && shAmt == pea_pkg::SH_8 && !snapNow
            |=> q.cnt[0] == $past(q.cnt[0]) + 32'h80;
    endproperty
    a_cntSlow: assert property (p_cntSlow) else $error("slow sample did not add 128 counts");

    // positive sample never lowers the sum, so no wrap and a full sum stays full
    property p_accSat;
        convOk && conv.ch == 2'h0 && !addP[29] && !snapNow
            |=> $signed(q.acc[0]) >= $signed($past(q.acc[0]));
    endproperty
    a_accSat: assert property (p_accSat) else $error("accumulator left its maximum");

    // slow rate changes only at a cycle end
    property p_slowNext;
        $changed(q.slowActive) |-> $past(cycleDone);
    endproperty
    a_slowNext: assert property (p_slowNext) else $error("slow rate changed inside a cycle");

    // slow edge without enable leaves results alone
    property p_noAutoSnap;
        slowEdge && !q.ctrl[pea_pkg::CTRL_SLOWSNAP] && !hostSnap |=> $stable(q.rdAcc);
    endproperty
    a_noAutoSnap: assert property (p_noAutoSnap) else $error("snapshot without enable");

    // window sums move only at cycle ends
    property p_sumHold;
        !cycleDone |=> $stable(q.sumBus) && $stable(q.sumShunt);
    endproperty
    a_sumHold: assert property (p_sumHold) else $error("rolling sum moved inside a cycle");

endmodule
`default_nettype wire

// ### bench/pea_conv_source.sv
// conversion sequencer model feeding finished codes to the accumulator
`timescale 1ns/1ps
`default_nettype none
module pea_conv_source (
    // clock
    input wire logic clk,
    // towards the accumulator
    output var pea_pkg::pea_conv_t conv,
    output var logic cycleDone
);
    // quiet bus before the first conversion
    initial begin
        conv = '0;
        cycleDone = 1'b0;
    end
    task automatic send(input logic [1:0] ch, input logic [16:0] bus, input logic [16:0] shunt);
        @(posedge clk);
        conv <= {1'b1, ch, bus, shunt};
        @(posedge clk);
        // stale codes show their inverse, so a late sample cannot pass
        conv <= {1'b0, ch, ~bus, ~shunt};
    endtask
    task automatic finish_cycle();
        // always one idle cycle after the last conversion
        @(posedge clk);
        cycleDone <= 1'b1;
        @(posedge clk);
        cycleDone <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### bench/pea_accumulator_tb_top.sv
// self-checking bench for the power energy accumulator
`timescale 1ns/1ps
`default_nettype none
module pea_accumulator_tb_top;
    logic clk;
    logic nrst;
    pea_pkg::pea_apb_req_t apbReq;
    pea_pkg::pea_apb_rsp_t apbRsp;
    pea_pkg::pea_conv_t conv;
    logic cycleDone;
    logic slowPin;
    logic [1:0] permSel;
    logic slowMode;
    logic avgValid;
    int badCount = 0;
    int samplesChecked = 0;

    pea_accumulator #(.NCH(4)) i_pea_accumulator (.clk(clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
        .conv(conv), .cycleDone(cycleDone), .slowPin(slowPin), .permSel(permSel), .slowMode(slowMode),
        .avgValid(avgValid));
    pea_conv_source i_pea_conv_source (.clk(clk), .conv(conv), .cycleDone(cycleDone));

    // 250 MHz clock
    always #2 clk = ~clk;

    // verdict and end of run
    task automatic stopTest();
        if (badCount == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        samplesChecked++;
        if (seen !== expv) begin
            badCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= wd;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 32);
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (apbRsp.pready !== 1'b1) begin
            badCount++;
            stopTest();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    // masked read compare
    task automatic rdchk(input logic [11:0] a, input logic [31:0] expv, input logic [31:0] mask);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        check(r & mask, expv);
    endtask

    function automatic logic [11:0] chAddr(input int c, input logic [2:0] idx);
        return pea_pkg::CH_BASE + 12'(c * 32) + {7'h00, idx, 2'b00};
    endfunction

    // register values straight after reset
    task automatic test_reset();
        rdchk(pea_pkg::ADDR_CTRL, 32'h00000009, 32'hffffffff);
        rdchk(pea_pkg::ADDR_FMT, 32'h00000000, 32'hffffffff);
        rdchk(pea_pkg::ADDR_STAT, 32'h00000000, 32'hffffffff);
    endtask

    // unmapped address answers with an error and no data
    task automatic test_unmapped();
        logic [31:0] r;
        logic e;
        apb(1'b0, 12'h050, 32'h00000000, r, e);
        check({31'h0, e}, 32'h00000001);
        check(r, 32'h00000000);
    endtask

    // fill and roll the eight-sample window, snapshot gating
    task automatic test_average();
        logic [16:0] code;
        for (int i = 1; i <= 9; i++) begin
            code = (i == 9) ? 17'h00200 : 17'(i * 16);
            i_pea_conv_source.send(2'h0, code, code);
            i_pea_conv_source.finish_cycle();
            // let the cycle-end updates land
            @(posedge clk);
            check({31'h0, avgValid}, (i >= 8) ? 32'h00000001 : 32'h00000000);
            check({30'h0, permSel}, 32'(i % 4));
        end
        rdchk(chAddr(0, pea_pkg::CH_BUSAVG), 32'h00000000, 32'hffffffff);
        wr(pea_pkg::ADDR_SNAP, 32'h00000002);
        // window 32..128 and 512: sum 1072, mean 134, shown without lsb
        rdchk(chAddr(0, pea_pkg::CH_BUSAVG), 32'h00000043, 32'h0000ffff);
        rdchk(chAddr(0, pea_pkg::CH_SHAVG), 32'h00000043, 32'h0000ffff);
        rdchk(chAddr(0, pea_pkg::CH_BUS), 32'h00000100, 32'h0000ffff);
        rdchk(pea_pkg::ADDR_STAT, 32'h00000005, 32'h0000000f);
    endtask

    // per-channel half span and bipolar formatting
    task automatic test_format();
        wr(pea_pkg::ADDR_FMT, 32'h00002203);
        rdchk(pea_pkg::ADDR_FMT, 32'h00002203, 32'hffffffff);
        i_pea_conv_source.send(2'h0, 17'h1fffe, 17'h12345);
        i_pea_conv_source.send(2'h1, 17'h08000, 17'h12345);
        i_pea_conv_source.finish_cycle();
        wr(pea_pkg::ADDR_SNAP, 32'h00000002);
        rdchk(chAddr(0, pea_pkg::CH_BUS), 32'h0000ffff, 32'h0000ffff);
        rdchk(chAddr(0, pea_pkg::CH_SHUNT), 32'h000091a2, 32'h0000ffff);
        rdchk(chAddr(1, pea_pkg::CH_BUS), 32'h00007fff, 32'h0000ffff);
        rdchk(chAddr(1, pea_pkg::CH_SHUNT), 32'h0000ffff, 32'h0000ffff);
        // bipolar bus makes the negative product signed, not clamped
        rdchk(chAddr(1, pea_pkg::CH_POW), 32'(-56507 * 4096), 32'hffffffff);
        wr(pea_pkg::ADDR_FMT, 32'h00000000);
    endtask

    // every programmed rate, plus adaptive off, two samples each
    task automatic test_rates();
        logic [2:0] shTab [5];
        logic [63:0] expAcc;
        logic [31:0] ctrl;
        shTab = '{pea_pkg::SH_1024, pea_pkg::SH_256, pea_pkg::SH_64, pea_pkg::SH_8, 3'h0};
        for (int r = 0; r < 5; r++) begin
            ctrl = (r < 4) ? (32'h00000009 | 32'(r << 1)) : 32'h0000000e;
            wr(pea_pkg::ADDR_CTRL, ctrl);
            wr(pea_pkg::ADDR_SNAP, 32'h00000001);
            i_pea_conv_source.send(2'h2, 17'h08000, 17'h00400);
            i_pea_conv_source.send(2'h2, 17'h08000, 17'h00400);
            i_pea_conv_source.finish_cycle();
            wr(pea_pkg::ADDR_SNAP, 32'h00000002);
            expAcc = 64'h0000000000800000 << shTab[r];
            rdchk(chAddr(2, pea_pkg::CH_POW), 32'h00400000, 32'hffffffff);
            rdchk(chAddr(2, pea_pkg::CH_ACCLO), expAcc[31:0], 32'hffffffff);
            rdchk(chAddr(2, pea_pkg::CH_ACCHI), expAcc[63:32], 32'hffffffff);
            rdchk(chAddr(2, pea_pkg::CH_CNT), 32'h00000002 << shTab[r], 32'hffffffff);
        end
    endtask

    // slow pin takes effect only from the next cycle
    task automatic test_slow();
        wr(pea_pkg::ADDR_CTRL, 32'h00000009);
        wr(pea_pkg::ADDR_SNAP, 32'h00000001);
        @(posedge clk);
        slowPin <= 1'b1;
        repeat (4) @(posedge clk);
        check({31'h0, slowMode}, 32'h00000000);
        i_pea_conv_source.send(2'h0, 17'h08000, 17'h00400);
        i_pea_conv_source.finish_cycle();
        @(posedge clk);
        check({31'h0, slowMode}, 32'h00000001);
        i_pea_conv_source.send(2'h0, 17'h08000, 17'h00400);
        i_pea_conv_source.finish_cycle();
        wr(pea_pkg::ADDR_SNAP, 32'h00000002);
        // one sample at full rate, one shifted by seven
        rdchk(chAddr(0, pea_pkg::CH_ACCLO), 32'h20400000, 32'hffffffff);
        rdchk(chAddr(0, pea_pkg::CH_CNT), 32'h00000081, 32'hffffffff);
        rdchk(pea_pkg::ADDR_STAT, 32'h00000002, 32'h00000002);
        // one more slow sample, then let the falling pin take the snapshot
        i_pea_conv_source.send(2'h0, 17'h08000, 17'h00400);
        wr(pea_pkg::ADDR_CTRL, 32'h00000019);
        @(posedge clk);
        slowPin <= 1'b0;
        repeat (4) @(posedge clk);
        rdchk(chAddr(0, pea_pkg::CH_ACCLO), 32'h40400000, 32'hffffffff);
        rdchk(chAddr(0, pea_pkg::CH_CNT), 32'h00000101, 32'hffffffff);
        // the pin snapshot also cleared the sum
        wr(pea_pkg::ADDR_SNAP, 32'h00000002);
        rdchk(chAddr(0, pea_pkg::CH_ACCLO), 32'h00000000, 32'hffffffff);
    endtask

    // main sequence
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        slowPin = 1'b0;
        apbReq = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        test_reset();
        test_unmapped();
        test_average();
        test_format();
        test_rates();
        test_slow();
        stopTest();
    end

    // hang guard, well above the longest run
    initial begin
        repeat (50000) @(posedge clk);
        badCount++;
        stopTest();
    end
endmodule
`default_nettype wire
